// ==== rtl/adt_decode_timing.v ====
// arithmetic decode group with busy timing and apb registers
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module adt_decode_timing
(
	// clock and reset
	input  wire        CLOCK,
	input  wire        RST,
	// apb slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	// execution state
	output reg         BUSY
);
`include "adt_map.vh"

	// ****************************************************************
	// registers and decode
	// ****************************************************************
	reg  [31:0] ctrl;
	reg  [15:0] instr;
	reg  [3:0]  op_id;
	reg  [4:0]  total;
	reg  [4:0]  remain;
	reg         wdest;
	reg         wide;
	reg         dir;
	reg         mem;
	reg         done;
	reg         unsup;
	reg  [7:0]  div_cnt;
	reg         tick;

	wire [3:0]  dec_op;
	wire [4:0]  dec_clocks;
	wire        dec_wdest;
	wire        dec_wide;
	wire        dec_dir;
	wire        dec_mem;

	adt_op_decode adt_op_decode_i
	(
		.opcode   (PWDATA[7:0]),
		.selector (PWDATA[15:8]),
		.op_id    (dec_op),
		.clocks   (dec_clocks),
		.wdest    (dec_wdest),
		.wide     (dec_wide),
		.dir      (dec_dir),
		.mem      (dec_mem)
	);

	// ****************************************************************
	// apb access
	// ****************************************************************
	wire access = PSEL & PENABLE & PREADY;
	wire wr     = access & PWRITE;
	wire mapped = (PADDR == `ADT_OFS_CTRL) || (PADDR == `ADT_OFS_INSTR) ||
		(PADDR == `ADT_OFS_STATUS);
	// a new instruction while busy is refused so timing is never cut short;
	// acceptance follows the registered error so both always agree
	wire wr_instr = wr && (PADDR == `ADT_OFS_INSTR) && !PSLVERR;
	wire refuse   = (PADDR == `ADT_OFS_INSTR) && PWRITE && BUSY;
	wire finish   = BUSY && tick && (remain == 5'h01);

	function [31:0] status_word;
		input [31:0] dummy;
		begin
			status_word = 32'h0000_0000;
			status_word[`ADT_ST_BUSY]  = BUSY;
			status_word[`ADT_ST_DONE]  = done;
			status_word[`ADT_ST_UNSUP] = unsup;
			status_word[`ADT_ST_OP_LSB+3:`ADT_ST_OP_LSB]   = op_id;
			status_word[`ADT_ST_TOT_LSB+4:`ADT_ST_TOT_LSB] = total;
			status_word[`ADT_ST_REM_LSB+4:`ADT_ST_REM_LSB] = remain;
			status_word[`ADT_ST_WDEST] = wdest;
			status_word[`ADT_ST_WIDE]  = wide;
			status_word[`ADT_ST_DIR]   = dir;
			status_word[`ADT_ST_MEM]   = mem;
		end
	endfunction

	// one wait state: pready rises in the second access cycle
	always @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
		end
		else
		begin
			PREADY  <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			if (PSEL & PENABLE & ~PREADY)
			begin
				PSLVERR <= ~mapped | refuse;
				if (!PWRITE)
				begin
					case (PADDR)
						`ADT_OFS_CTRL:   PRDATA <= ctrl;
						`ADT_OFS_INSTR:  PRDATA <= {16'h0000, instr};
						`ADT_OFS_STATUS: PRDATA <= status_word(32'h0000_0000);
						default:         PRDATA <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// processor clock enable
	// ****************************************************************
	always @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			div_cnt <= 8'h00;
			tick    <= 1'b0;
		end
		else if (div_cnt >= ctrl[`ADT_CTRL_DIV_MSB:`ADT_CTRL_DIV_LSB])
		begin
			div_cnt <= 8'h00;
			tick    <= ctrl[`ADT_CTRL_EN];
		end
		else
		begin
			div_cnt <= div_cnt + 8'h01;
			tick    <= 1'b0;
		end
	end

	// ****************************************************************
	// control, decode capture and busy timing
	// ****************************************************************
	always @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			ctrl   <= `ADT_CTRL_RESET;
			instr  <= 16'h0000;
			op_id  <= `ADT_OP_NONE;
			total  <= 5'h00;
			remain <= 5'h00;
			wdest  <= 1'b0;
			wide   <= 1'b0;
			dir    <= 1'b0;
			mem    <= 1'b0;
			done   <= 1'b0;
			unsup  <= 1'b0;
			BUSY   <= 1'b0;
		end
		else
		begin
			if (wr && PADDR == `ADT_OFS_CTRL)
				ctrl <= PWDATA;
			// write one to clear; a completion in the same cycle wins
			if (wr && PADDR == `ADT_OFS_STATUS)
			begin
				if (PWDATA[`ADT_ST_DONE])
					done <= 1'b0;
				if (PWDATA[`ADT_ST_UNSUP])
					unsup <= 1'b0;
			end
			if (finish)
			begin
				BUSY   <= 1'b0;
				remain <= 5'h00;
				done   <= 1'b1;
			end
			else if (BUSY && tick)
				remain <= remain - 5'h01;
			if (wr_instr)
			begin
				instr  <= PWDATA[15:0];
				op_id  <= dec_op;
				total  <= dec_clocks;
				remain <= dec_clocks;
				wdest  <= dec_wdest;
				wide   <= dec_wide;
				dir    <= dec_dir;
				mem    <= dec_mem;
				if (dec_op == `ADT_OP_NONE)
					unsup <= 1'b1;
				else
					BUSY <= 1'b1;
			end
		end
	end

endmodule // adt_decode_timing

// ==== inc/adt_map.vh ====
// constants for the arithmetic decode and timing group
// ****************************************************************
// Summary of operation
// - Opcode 000110dw with a following operand selector byte decodes as register or memory subtract with borrow, d picking the destination and w the width.
// - Immediate subtract with borrow decodes from 100000sw with field 011 for register or memory, and from 0001110w for the accumulator in 3 clocks.
// - Opcode 00110111 is the ascii adjust after add on the accumulator and takes 3 clocks in both modes.
// - Opcode 00100111 is the decimal adjust after add on the low accumulator byte and takes 3 clocks in both modes.
// - Opcode 00111111 is the ascii adjust after subtract on the accumulator and takes 3 clocks in both modes.
// - Opcode 00101111 is the decimal adjust after subtract on the low accumulator byte and takes 3 clocks in both modes.
// - Unsigned multiply decodes from 1111011w with field 100 and takes 13, 21, 16 or 24 clocks for byte register, word register, byte memory and word memory.
// - Signed multiply decodes from 1111011w with field 101 and uses the same 13, 21, 16 and 24 clock counts.
// ****************************************************************
`ifndef ADT_MAP_VH
`define ADT_MAP_VH

// register byte offsets
`define ADT_OFS_CTRL      12'h000
`define ADT_OFS_INSTR     12'h004
`define ADT_OFS_STATUS    12'h008

// control fields
`define ADT_CTRL_EN       0
`define ADT_CTRL_DIV_LSB  8
`define ADT_CTRL_DIV_MSB  15
`define ADT_CTRL_RESET    32'h0000_0001

// status fields
`define ADT_ST_BUSY       0
`define ADT_ST_DONE       1
`define ADT_ST_UNSUP      2
`define ADT_ST_OP_LSB     4
`define ADT_ST_TOT_LSB    8
`define ADT_ST_REM_LSB    16
`define ADT_ST_WDEST      24
`define ADT_ST_WIDE       25
`define ADT_ST_DIR        26
`define ADT_ST_MEM        27

// operation identifiers
`define ADT_OP_NONE       4'h0
`define ADT_OP_SBB        4'h1
`define ADT_OP_DEC        4'h2
`define ADT_OP_CMP        4'h3
`define ADT_OP_NEG        4'h4
`define ADT_OP_AAA        4'h5
`define ADT_OP_DAA        4'h6
`define ADT_OP_AAS        4'h7
`define ADT_OP_DAS        4'h8
`define ADT_OP_MUL        4'h9
`define ADT_OP_SIGNED_MULTIPLY_OP       4'ha

// operation select field values
`define ADT_SEL_SBB       3'h3
`define ADT_SEL_DEC       3'h1
`define ADT_SEL_CMP       3'h7
`define ADT_SEL_NEG       3'h3
`define ADT_SEL_MUL       3'h4
`define ADT_SEL_SIGNED_MULTIPLY_OP      3'h5

// processor clock counts
`define ADT_CLK_REG       5'h02
`define ADT_CLK_IMM       5'h03
`define ADT_CLK_ADJ       5'h03
`define ADT_CLK_MEM       5'h07
`define ADT_CLK_CMP_MEM   5'h06
`define ADT_CLK_MUL_RB    5'h0d
`define ADT_CLK_MUL_RW    5'h15
`define ADT_CLK_MUL_MB    5'h10
`define ADT_CLK_MUL_MW    5'h18

`endif

// ==== rtl/adt_op_decode.v ====
// opcode and operand selector decode with clock counts
`timescale 1ns/1ps
module adt_op_decode
(
	// instruction bytes
	input  wire [7:0] opcode,
	input  wire [7:0] selector,
	// decode result
	output reg  [3:0] op_id,
	output reg  [4:0] clocks,
	output reg        wdest,
	output reg        wide,
	output reg        dir,
	output reg        mem
);
`include "adt_map.vh"

	wire [2:0] sel = selector[5:3];
	wire       is_mem = (selector[7:6] != 2'h3);

	// register form or memory form count
	function [4:0] rm_count;
		input       m;
		input [4:0] r_cnt;
		input [4:0] m_cnt;
		begin
			rm_count = m ? m_cnt : r_cnt;
		end
	endfunction

	always @*
	begin
		op_id  = `ADT_OP_NONE;
		clocks = 5'h00;
		wdest  = 1'b1;
		wide   = opcode[0];
		dir    = 1'b0;
		mem    = 1'b0;
		if (opcode[7:2] == 6'b000110)
		begin
			op_id  = `ADT_OP_SBB;
			dir    = opcode[1];
			mem    = is_mem;
			clocks = rm_count(is_mem, `ADT_CLK_REG, `ADT_CLK_MEM);
		end
		else if (opcode[7:2] == 6'b100000 &&
			(sel == `ADT_SEL_SBB || sel == `ADT_SEL_CMP))
		begin
			op_id  = (sel == `ADT_SEL_SBB) ? `ADT_OP_SBB : `ADT_OP_CMP;
			wdest  = (sel == `ADT_SEL_SBB);
			mem    = is_mem;
			clocks = rm_count(is_mem, `ADT_CLK_IMM,
				(sel == `ADT_SEL_SBB) ? `ADT_CLK_MEM : `ADT_CLK_CMP_MEM);
		end
		else if (opcode[7:1] == 7'b0001110)
		begin
			op_id  = `ADT_OP_SBB;
			clocks = `ADT_CLK_IMM;
		end
		else if (opcode[7:1] == 7'b1111111 && sel == `ADT_SEL_DEC)
		begin
			op_id  = `ADT_OP_DEC;
			mem    = is_mem;
			clocks = rm_count(is_mem, `ADT_CLK_REG, `ADT_CLK_MEM);
		end
		else if (opcode[7:3] == 5'b01001)
		begin
			op_id  = `ADT_OP_DEC;
			wide   = 1'b1;
			clocks = `ADT_CLK_REG;
		end
		else if (opcode[7:2] == 6'b001110)
		begin
			// flags only, the destination is never written
			op_id  = `ADT_OP_CMP;
			wdest  = 1'b0;
			dir    = opcode[1];
			mem    = is_mem;
			clocks = rm_count(is_mem, `ADT_CLK_REG, `ADT_CLK_CMP_MEM);
		end
		else if (opcode[7:1] == 7'b0011110)
		begin
			op_id  = `ADT_OP_CMP;
			wdest  = 1'b0;
			clocks = `ADT_CLK_IMM;
		end
		else if (opcode[7:1] == 7'b1111011 && sel == `ADT_SEL_NEG)
		begin
			op_id  = `ADT_OP_NEG;
			mem    = is_mem;
			clocks = rm_count(is_mem, `ADT_CLK_REG, `ADT_CLK_MEM);
		end
		else if (opcode[7:1] == 7'b1111011 &&
			(sel == `ADT_SEL_MUL || sel == `ADT_SEL_SIGNED_MULTIPLY_OP))
		begin
			op_id  = (sel == `ADT_SEL_MUL) ? `ADT_OP_MUL : `ADT_OP_SIGNED_MULTIPLY_OP;
			mem    = is_mem;
			if (opcode[0])
				clocks = rm_count(is_mem, `ADT_CLK_MUL_RW, `ADT_CLK_MUL_MW);
			else
				clocks = rm_count(is_mem, `ADT_CLK_MUL_RB, `ADT_CLK_MUL_MB);
		end
		else
		begin
			case (opcode)
				8'h37:
				begin
					op_id  = `ADT_OP_AAA;
					clocks = `ADT_CLK_ADJ;
				end
				8'h27:
				begin
					op_id  = `ADT_OP_DAA;
					wide   = 1'b0;
					clocks = `ADT_CLK_ADJ;
				end
				8'h3f:
				begin
					op_id  = `ADT_OP_AAS;
					clocks = `ADT_CLK_ADJ;
				end
				8'h2f:
				begin
					op_id  = `ADT_OP_DAS;
					wide   = 1'b0;
					clocks = `ADT_CLK_ADJ;
				end
				default:
				begin
					wdest = 1'b0;
					wide  = 1'b0;
				end
			endcase
		end
	end

endmodule // adt_op_decode

// ==== dv/adt_decode_timing_monitor.sv ====
// bus and busy timing checks for the arithmetic decode group
`timescale 1ns/1ps
module adt_decode_timing_monitor
(
	// clock and reset
	input wire        CLOCK,
	input wire        RST,
	// apb
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	// state
	input wire        BUSY
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	sequence setup_s; PSEL && !PENABLE; endsequence
	sequence done_s; PSEL && PENABLE && PREADY; endsequence
	sequence instr_s; done_s ##0 (PWRITE && PADDR == 12'h004); endsequence
	wait_state_a: assert property (setup_s |=> !PREADY ##1 PREADY)
		else $error("ready not after one wait state");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data not zero while idle");
	err_valid_a: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	unmapped_err_a: assert property (done_s ##0 (PADDR > 12'h008) |-> PSLVERR)
		else $error("unmapped access not refused");
	busy_refuse_a: assert property (instr_s ##0 BUSY |-> PSLVERR)
		else $error("instruction accepted while busy");
	busy_cause_a: assert property ($rose(BUSY) |-> $past(PREADY) && $past(PWRITE) &&
		$past(PADDR) == 12'h004)
		else $error("busy without instruction write");
	busy_min_a: assert property ($rose(BUSY) |-> BUSY [*2])
		else $error("busy shorter than two clocks");
	busy_max_a: assert property ($rose(BUSY) |-> ##[2:40] !BUSY)
		else $error("busy longer than longest count");
endmodule // adt_decode_timing_monitor

bind adt_decode_timing adt_decode_timing_monitor adt_decode_timing_monitor_i (.CLOCK(CLOCK),
	.RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY(BUSY));

// ==== dv/adt_fetch_model.sv ====
// instruction stream model with expected decode per entry
`timescale 1ns/1ps
module adt_fetch_model
(
	// entry select
	input wire [4:0] idx,
	// opcode, selector, op id, clocks, writes dest
	output reg [25:0] ent
);
	// ****************
	// table
	// ****************
	always @*
	begin
		case (idx)
		5'h00: ent = {8'h18, 8'hc0, 4'h1, 5'h02, 1'b1};
		5'h01: ent = {8'h19, 8'h00, 4'h1, 5'h07, 1'b1};
		5'h02: ent = {8'h80, 8'hd8, 4'h1, 5'h03, 1'b1};
		5'h03: ent = {8'h1c, 8'h00, 4'h1, 5'h03, 1'b1};
		5'h04: ent = {8'h37, 8'h00, 4'h5, 5'h03, 1'b1};
		5'h05: ent = {8'h27, 8'h00, 4'h6, 5'h03, 1'b1};
		5'h06: ent = {8'h3f, 8'h00, 4'h7, 5'h03, 1'b1};
		5'h07: ent = {8'h2f, 8'h00, 4'h8, 5'h03, 1'b1};
		5'h08: ent = {8'hf6, 8'he0, 4'h9, 5'h0d, 1'b1};
		5'h09: ent = {8'hf7, 8'he0, 4'h9, 5'h15, 1'b1};
		5'h0a: ent = {8'hf6, 8'h20, 4'h9, 5'h10, 1'b1};
		5'h0b: ent = {8'hf7, 8'h20, 4'h9, 5'h18, 1'b1};
		5'h0c: ent = {8'hf7, 8'he8, 4'ha, 5'h15, 1'b1};
		5'h0d: ent = {8'hf6, 8'h28, 4'ha, 5'h10, 1'b1};
		5'h0e: ent = {8'hfe, 8'hc8, 4'h2, 5'h02, 1'b1};
		5'h0f: ent = {8'h49, 8'h00, 4'h2, 5'h02, 1'b1};
		5'h10: ent = {8'h83, 8'h38, 4'h3, 5'h06, 1'b0};
		5'h11: ent = {8'h3a, 8'h00, 4'h3, 5'h06, 1'b0};
		5'h12: ent = {8'h3c, 8'h00, 4'h3, 5'h03, 1'b0};
		5'h13: ent = {8'hf7, 8'h18, 4'h4, 5'h07, 1'b1};
		default: ent = {8'h80, 8'hf8, 4'h3, 5'h03, 1'b0};
		endcase
	end
endmodule // adt_fetch_model

// ==== dv/adt_decode_timing_bench.sv ====
// self-checking bench for the arithmetic decode group
`timescale 1ns/1ps
module adt_decode_timing_bench;
	// ****************
	// signals
	// ****************
	reg         clock = 1'b0;
	reg         rst = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg  [31:0] rd;
	reg         er;
	reg  [4:0]  idx = 5'h00;
	wire [25:0] ent;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        busy;
	integer     errors = 0;
	integer     compares = 0;
	integer     i;
	initial forever #2.5 clock = ~clock;
	adt_decode_timing adt_decode_timing_i (.CLOCK(clock), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUSY(busy));
	adt_fetch_model adt_fetch_model_i (.idx(idx), .ent(ent));
	// ****************
	// tasks
	// ****************
	task chk(input string nm, input [31:0] e, input [31:0] s);
	begin
		compares = compares + 1;
		if (s !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			errors = errors + 1;
		end
	end
	endtask
	// master holds the request until ready is sampled high
	task apb(input w, input [11:0] a, input [31:0] d);
		integer n;
	begin
		n = 0;
		@(posedge clock);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin @(posedge clock); n = n + 1; end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n >= 20) chk("pready", 1, 0);
	end
	endtask
	task wait_idle;
		integer n;
	begin
		n = 0;
		repeat (2) @(posedge clock);
		while (busy !== 1'b0 && n < 200) begin @(posedge clock); n = n + 1; end
		if (n >= 200) chk("busy end", 0, 1);
	end
	endtask
	task complete_run;
	begin
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	// ****************
	// tests
	// ****************
	initial
	begin
		#100000;
		errors = errors + 1;
		complete_run;
	end
	initial
	begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		apb(0, 12'h000, 0); chk("ctrl reset", 32'h1, rd);
		apb(0, 12'h00c, 0); chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		$display("register test done");
		for (i = 0; i < 21; i = i + 1)
		begin
			idx <= i[4:0];
			// let the table settle before its bytes are taken as arguments
			@(posedge clock);
			apb(1, 12'h004, {16'h0, ent[17:10], ent[25:18]});
			// second write lands inside a long busy span
			if (i == 9) begin apb(1, 12'h004, 32'h37); chk("busy refuse", 1, er); end
			wait_idle;
			apb(0, 12'h008, 0);
			chk("op id", ent[9:6], rd[7:4]);
			chk("clocks", ent[5:1], rd[12:8]);
			chk("writes dest", ent[0], rd[24]);
			chk("done", 1, rd[1]);
			if (i == 1) chk("sbb mem dir wide", 3'b101, rd[27:25]);
			apb(1, 12'h008, 32'h2);
		end
		$display("decode test done");
		apb(1, 12'h004, 32'hc000);
		repeat (3) @(posedge clock);
		chk("unsup busy", 0, busy);
		apb(0, 12'h008, 0); chk("unsup flag", 1, rd[2]);
		$display("refusal test done");
		apb(1, 12'h000, 32'h0000_0300);
		apb(1, 12'h004, 32'h37);
		repeat (10) @(posedge clock);
		chk("halted busy", 1, busy);
		apb(1, 12'h000, 32'h1);
		wait_idle;
		apb(0, 12'h008, 0);
		chk("resume done", 1, rd[1]);
		chk("resume clocks", 3, rd[12:8]);
		$display("enable test done");
		complete_run;
	end
endmodule // adt_decode_timing_bench
